// [mtr_pkg.sv]
// constants, types and addresses shared by the metering pin interface
// Behaviour
// - While reset is asserted the core, the serial port and every output stay in reset.
// - Conversion and processing logic runs from the master clock input.
// - The power pulse output rate follows positive power, scaled by numerator plus one over 256 times denominator plus one.
// - The zero crossing output toggles at every sign change of the voltage samples.
// - The open-drain sag output pulls low when zero crossings stop or voltage stays low too long.
// - The interrupt output is active low open-drain, driven low to assert, released otherwise.
// - Energy rollover, energy half level and new waveform sample are individually maskable sources.
// - The host selects the device with an active-low chip select; the port answers only when selected.
// - The host supplies the serial clock and every serial transfer runs on it.
// - Read data bits are shifted onto the data output on rising serial clock edges.
// - The data output is released except while read data is being driven.
// - Input data is sampled on falling serial clock edges.
package mtr_pkg;
	localparam int CLK_HZ          = 20_000_000;
	localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
	localparam int MASTER_CLK_HZ   = 3_579_545;
	localparam int CMD_BITS        = 8;
	localparam int DATA_BITS       = 16;
	localparam int CMD_WRITE_BIT   = 7;
	localparam int ADDR_BITS       = 6;
	localparam int READ_WAIT_NS    = 4000;
	localparam int WAVE_WAIT_NS    = 500;
	localparam int READ_WAIT_CYC   = (READ_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int WAVE_WAIT_CYC   = (WAVE_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int CF_PULSE_NS     = 1000;
	localparam int CF_PULSE_CYC    = (CF_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int CF_SHIFT        = 8;
	localparam int NOZX_TIME_US    = 20000;
	localparam int NOZX_CYC_DEF    = NOZX_TIME_US * CLK_MHZ;
	localparam int ST_BITS         = 3;
	localparam int ST_ROLL         = 0;
	localparam int ST_HALF         = 1;
	localparam int ST_WAVE         = 2;
	localparam logic [5:0]  ADDR_WAVE     = 6'h01;
	localparam logic [5:0]  ADDR_ENERGY   = 6'h02;
	localparam logic [5:0]  ADDR_PULSE_RATE_NUMERATOR    = 6'h03;
	localparam logic [5:0]  ADDR_PULSE_RATE_DENOMINATOR    = 6'h04;
	localparam logic [5:0]  ADDR_IRQEN    = 6'h05;
	localparam logic [5:0]  ADDR_STATUS   = 6'h06;
	localparam logic [5:0]  ADDR_RSTSTAT  = 6'h07;
	localparam logic [5:0]  ADDR_SAGLVL   = 6'h08;
	localparam logic [5:0]  ADDR_SAGCYC   = 6'h09;
	localparam logic [15:0] PULSE_RATE_NUMERATOR_RST     = 16'h0000;
	localparam logic [15:0] PULSE_RATE_DENOMINATOR_RST     = 16'h003F;
	localparam logic [2:0]  IRQEN_RST     = 3'h0;
	localparam logic [15:0] SAGLVL_RST    = 16'h0800;
	localparam logic [15:0] SAGCYC_RST    = 16'h0010;
	typedef enum logic [2:0] {
		MTR_PH_CMD  = 3'b001,
		MTR_PH_DATA = 3'b010,
		MTR_PH_DONE = 3'b100
	} mtr_phase_e;
endpackage

// [mtr_xfer_if.sv]
// register transfer signals between serial port and core
`timescale 1ns/1ns
interface mtr_xfer_if;
	logic        rd_tgl;
	logic        wr_tgl;
	logic [7:0]  cmd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport serial (output rd_tgl, output wr_tgl, output cmd, output wdata, input rdata);
	modport core   (input rd_tgl, input wr_tgl, input cmd, input wdata, output rdata);
endinterface

// [mtr_serial.sv]
// serial port logic on the host's serial clock
`timescale 1ns/1ns
module mtr_serial (
	// link
	input  wire logic   sclk,
	input  wire logic   cs_n,
	input  wire logic   din,
	input  wire logic   rst,
	output logic        dout,
	output logic        dout_oe,
	// core side
	mtr_xfer_if.serial  xif
);
	import mtr_pkg::*;
	mtr_phase_e  phase_q;
	logic [3:0]  cnt_q;
	logic [14:0] sh_q;
	logic        frame_rst;
	logic        cmd_end;
	logic        data_end;
	logic        is_write;
	logic        dout_q;
	logic        oe_q;
	logic        rd_tgl_q;
	logic        wr_tgl_q;
	logic [7:0]  cmd_q;
	logic [15:0] wdata_q;

	// deselect ends the frame even with sclk parked
	assign frame_rst = rst | cs_n;
	assign cmd_end   = (phase_q == MTR_PH_CMD) && (cnt_q == 4'(CMD_BITS - 1));
	assign data_end  = (phase_q == MTR_PH_DATA) && (cnt_q == 4'(DATA_BITS - 1));
	assign is_write  = cmd_q[CMD_WRITE_BIT];

	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			phase_q <= MTR_PH_CMD;
			cnt_q   <= 4'h0;
			sh_q    <= 15'h0000;
		end else begin
			sh_q  <= {sh_q[13:0], din};
			cnt_q <= (cmd_end || data_end) ? 4'h0 : cnt_q + 4'h1;
			unique case (phase_q)
				MTR_PH_CMD:  phase_q <= cmd_end ? MTR_PH_DATA : MTR_PH_CMD;
				MTR_PH_DATA: phase_q <= data_end ? MTR_PH_DONE : MTR_PH_DATA;
				MTR_PH_DONE: phase_q <= MTR_PH_DONE;
			endcase
		end
	end

	// held past deselect so the core can still pick them up
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			cmd_q    <= 8'h00;
			wdata_q  <= 16'h0000;
			rd_tgl_q <= 1'b0;
			wr_tgl_q <= 1'b0;
		end else begin
			if (cmd_end) begin
				cmd_q    <= {sh_q[6:0], din};
				rd_tgl_q <= rd_tgl_q ^ ~sh_q[6];
			end
			if (data_end && is_write) begin
				wdata_q  <= {sh_q, din};
				wr_tgl_q <= ~wr_tgl_q;
			end
		end
	end

	// rdata is steady here because the host waits before clocking read bits
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			dout_q <= 1'b0;
			oe_q   <= 1'b0;
		end else begin
			oe_q   <= (phase_q == MTR_PH_DATA) && !is_write;
			dout_q <= xif.rdata[~cnt_q];
		end
	end

	assign dout       = dout_q;
	assign dout_oe    = oe_q;
	assign xif.rd_tgl = rd_tgl_q;
	assign xif.wr_tgl = wr_tgl_q;
	assign xif.cmd    = cmd_q;
	assign xif.wdata  = wdata_q;

	oe_only_read_a: assert property (@(posedge sclk) disable iff (frame_rst)
		oe_q |-> !is_write && (phase_q != MTR_PH_CMD))
		else $error("data output driven outside a read");
endmodule // mtr_serial

// [mtr_pins.sv]
// metering device digital core with serial port and status pins
`timescale 1ns/1ns
module mtr_pins #(
	parameter int NOZX_CYCLES = mtr_pkg::NOZX_CYC_DEF
) (
	// master clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// samples from the converters
	input  wire logic         sample_valid,
	input  wire logic [15:0]  volt_sample,
	input  wire logic [15:0]  power_sample,
	// serial link
	input  wire logic         sclk,
	input  wire logic         cs_n,
	input  wire logic         din,
	output logic              dout,
	output logic              dout_oe,
	// status pins
	output logic              power_pulse_out,
	output logic              zero_cross_out,
	output logic              sag_out,
	output logic              sag_oe,
	output logic              irq_out,
	output logic              irq_oe
);
	import mtr_pkg::*;
	localparam int NZW        = $clog2(NOZX_CYCLES + 1);
	localparam int PW         = $clog2(CF_PULSE_CYC + 1);

	if (NOZX_CYCLES < 2) begin : g_chk
		$error("NOZX_CYCLES too small");
	end

	mtr_xfer_if xif ();

	mtr_serial u_serial (
		.sclk    (sclk),
		.cs_n    (cs_n),
		.din     (din),
		.rst     (rst),
		.dout    (dout),
		.dout_oe (dout_oe),
		.xif     (xif)
	);

	logic [2:0]      rd_sync_q;
	logic [2:0]      wr_sync_q;
	logic            rd_evt;
	logic            wr_evt;
	logic [5:0]      addr;
	logic [15:0]     pulse_rate_numerator_q;
	logic [15:0]     pulse_rate_denominator_q;
	logic [2:0]      irqen_q;
	logic [15:0]     saglvl_q;
	logic [15:0]     sagcyc_q;
	logic [2:0]      status_q;
	logic [2:0]      status_d;
	logic [2:0]      set_vec;
	logic [2:0]      clr_vec;
	logic [15:0]     wave_q;
	logic [15:0]     energy_q;
	logic [15:0]     energy_sum;
	logic [15:0]     rdata_q;
	logic [15:0]     rd_mux;
	logic            roll_evt;
	logic            half_evt;
	logic            vsign_q;
	logic            zx_q;
	logic            zx_evt;
	logic [NZW-1:0]  nozx_q;
	logic            nozx;
	logic [15:0]     abs_v;
	logic            v_low;
	logic [15:0]     lowcnt_q;
	logic            sag_low;
	logic            sag_q;
	logic            irq_q;
	logic [14:0]     p_mag;
	logic [16:0]     num_p1;
	logic [16:0]     den_p1;
	logic [33:0]     cf_inc;
	logic [33:0]     cf_thr;
	logic [33:0]     cf_acc_q;
	logic [33:0]     cf_sum;
	logic [33:0]     cf_cap;
	logic            cf_fire;
	logic [PW-1:0]   pulse_cnt_q;
	logic            pulse_q;

	// toggles cross by two flops; stage 0 feeds only stage 1
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_sync_q <= 3'h0;
			wr_sync_q <= 3'h0;
		end else begin
			rd_sync_q <= {rd_sync_q[1:0], xif.rd_tgl};
			wr_sync_q <= {wr_sync_q[1:0], xif.wr_tgl};
		end
	end

	assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];
	assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
	assign addr   = xif.cmd[ADDR_BITS-1:0];

	// register read selection
	assign rd_mux = (addr == ADDR_WAVE)    ? wave_q :
	                (addr == ADDR_ENERGY)  ? energy_q :
	                (addr == ADDR_PULSE_RATE_NUMERATOR)   ? pulse_rate_numerator_q :
	                (addr == ADDR_PULSE_RATE_DENOMINATOR)   ? pulse_rate_denominator_q :
	                (addr == ADDR_IRQEN)   ? {13'h0000, irqen_q} :
	                (addr == ADDR_STATUS)  ? {13'h0000, status_q} :
	                (addr == ADDR_RSTSTAT) ? {13'h0000, status_q} :
	                (addr == ADDR_SAGLVL)  ? saglvl_q :
	                (addr == ADDR_SAGCYC)  ? sagcyc_q : 16'h0000;

	// word is latched once per read command, so it holds while the host shifts it
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rdata_q <= 16'h0000;
		else if (rd_evt)
			rdata_q <= rd_mux;
	end

	assign xif.rdata = rdata_q;

	// host writes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pulse_rate_numerator_q  <= PULSE_RATE_NUMERATOR_RST;
			pulse_rate_denominator_q  <= PULSE_RATE_DENOMINATOR_RST;
			irqen_q  <= IRQEN_RST;
			saglvl_q <= SAGLVL_RST;
			sagcyc_q <= SAGCYC_RST;
		end else if (wr_evt) begin
			if (addr == ADDR_PULSE_RATE_NUMERATOR)  pulse_rate_numerator_q  <= xif.wdata;
			if (addr == ADDR_PULSE_RATE_DENOMINATOR)  pulse_rate_denominator_q  <= xif.wdata;
			if (addr == ADDR_IRQEN)  irqen_q  <= xif.wdata[ST_BITS-1:0];
			if (addr == ADDR_SAGLVL) saglvl_q <= xif.wdata;
			if (addr == ADDR_SAGCYC) sagcyc_q <= xif.wdata;
		end
	end

	// energy accumulation on the master clock
	assign energy_sum = energy_q + power_sample;
	assign roll_evt   = sample_valid && (energy_q[15] == power_sample[15])
	                    && (energy_sum[15] != energy_q[15]);
	assign half_evt   = sample_valid && (energy_sum[14] ^ energy_sum[15])
	                    && !(energy_q[14] ^ energy_q[15]);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			energy_q <= 16'h0000;
			wave_q   <= 16'h0000;
		end else if (sample_valid) begin
			energy_q <= energy_sum;
			wave_q   <= volt_sample;
		end
	end

	// sticky sources; a set in the clearing cycle survives
	assign set_vec  = {sample_valid, half_evt, roll_evt};
	assign clr_vec  = (rd_evt && addr == ADDR_RSTSTAT) ? 3'h7 : 3'h0;
	assign status_d = (status_q & ~clr_vec) | set_vec;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status_q <= 3'h0;
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q    <= |(status_d & irqen_q);
		end
	end

	// zero crossing on voltage sign change
	assign zx_evt = sample_valid && (volt_sample[15] != vsign_q);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vsign_q <= 1'b0;
			zx_q    <= 1'b0;
		end else if (sample_valid) begin
			vsign_q <= volt_sample[15];
			zx_q    <= zx_q ^ zx_evt;
		end
	end

	// sag: missing crossings or a run of low samples
	assign nozx    = (nozx_q == NZW'(NOZX_CYCLES));
	assign abs_v   = volt_sample[15] ? 16'(-volt_sample) : volt_sample;
	assign v_low   = abs_v < saglvl_q;
	assign sag_low = (sagcyc_q != 16'h0000) && (lowcnt_q >= sagcyc_q);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			nozx_q   <= '0;
			lowcnt_q <= 16'h0000;
			sag_q    <= 1'b0;
		end else begin
			nozx_q <= zx_evt ? '0 : (nozx ? nozx_q : nozx_q + NZW'(1));
			if (sample_valid)
				lowcnt_q <= !v_low ? 16'h0000 : lowcnt_q + 16'(lowcnt_q != 16'hFFFF);
			sag_q <= nozx || sag_low;
		end
	end

	// pulse rate: positive power times numerator plus one against 256 times denominator plus one
	assign p_mag   = power_sample[15] ? 15'h0000 : power_sample[14:0];
	assign num_p1  = {1'b0, pulse_rate_numerator_q} + 17'h00001;
	assign den_p1  = {1'b0, pulse_rate_denominator_q} + 17'h00001;
	// widen before the product so large numerators do not wrap
	assign cf_inc  = sample_valid ? 34'(p_mag) * 34'(num_p1) : 34'h0;
	assign cf_thr  = 34'({den_p1, 8'h00}) << (CF_SHIFT - 8);
	assign cf_fire = (cf_acc_q >= cf_thr) && (pulse_cnt_q == '0);
	assign cf_sum  = cf_acc_q + cf_inc - (cf_fire ? cf_thr : 34'h0);
	// clamped: past one pulse per width window the rate saturates
	assign cf_cap  = (cf_sum > (cf_thr << 1)) ? (cf_thr << 1) : cf_sum;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cf_acc_q    <= 34'h0;
			pulse_cnt_q <= '0;
			pulse_q     <= 1'b0;
		end else begin
			cf_acc_q    <= cf_cap;
			pulse_cnt_q <= cf_fire ? PW'(CF_PULSE_CYC) :
			               (pulse_cnt_q != '0) ? pulse_cnt_q - PW'(1) : pulse_cnt_q;
			pulse_q     <= cf_fire || (pulse_cnt_q > PW'(1));
		end
	end

	// open-drain sag and irq pins: level is always low, only the enable moves
	assign power_pulse_out = pulse_q;
	assign zero_cross_out  = zx_q;
	assign sag_out         = 1'b0;
	assign sag_oe          = sag_q;
	assign irq_out         = 1'b0;
	assign irq_oe          = irq_q;

	set_wins_a: assert property (@(posedge clock) disable iff (rst)
		roll_evt && clr_vec[ST_ROLL] |=> status_q[ST_ROLL])
		else $error("rollover lost while clearing");
	irq_drive_a: assert property (@(posedge clock) disable iff (rst)
		$stable(irqen_q) && (|(status_q & irqen_q)) |-> irq_oe)
		else $error("enabled source without interrupt");
	irq_mask_a: assert property (@(posedge clock) disable iff (rst)
		(irqen_q == 3'h0) && $stable(irqen_q) |-> !irq_oe)
		else $error("masked source raised interrupt");
	zx_toggle_a: assert property (@(posedge clock) disable iff (rst)
		zx_evt |=> zero_cross_out != $past(zero_cross_out))
		else $error("crossing without toggle");
	zx_hold_a: assert property (@(posedge clock) disable iff (rst)
		!sample_valid |=> $stable(zero_cross_out))
		else $error("toggle without sample");
	sag_nozx_a: assert property (@(posedge clock) disable iff (rst)
		nozx |=> sag_oe)
		else $error("no sag on missing crossings");
	sag_clear_a: assert property (@(posedge clock) disable iff (rst)
		!nozx && !sag_low |=> !sag_oe)
		else $error("sag without cause");
	pulse_width_a: assert property (@(posedge clock) disable iff (rst)
		$rose(power_pulse_out) |-> power_pulse_out[*8])
		else $error("power pulse too short");
	read_latch_a: assert property (@(posedge clock) disable iff (rst)
		$changed(xif.rd_tgl) |-> ##2 rd_evt ##1 (rdata_q == $past(rd_mux)))
		else $error("read word not latched in time");
	write_num_a: assert property (@(posedge clock) disable iff (rst)
		wr_evt && addr == ADDR_PULSE_RATE_NUMERATOR |=> pulse_rate_numerator_q == $past(xif.wdata))
		else $error("numerator write lost");

	zx_seen_c:    cover property (@(posedge clock) disable iff (rst) zx_evt);
	sag_seen_c:   cover property (@(posedge clock) disable iff (rst) $rose(sag_oe));
	irq_seen_c:   cover property (@(posedge clock) disable iff (rst) $rose(irq_oe));
	pulse_seen_c: cover property (@(posedge clock) disable iff (rst) $rose(power_pulse_out));
endmodule // mtr_pins

// [mtr_host_model.sv]
// host model driving the serial port of the metering core
`timescale 1ns/1ns
module mtr_host_model (
	// serial link
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	import mtr_pkg::*;
	logic oe_early;
	initial begin
		sclk     = 1'b0;
		cs_n     = 1'b1;
		din      = 1'b0;
		oe_early = 1'b0;
	end
	// nbits under 24 cuts the frame short; sclk stands still outside frames
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nbits,
		output logic [15:0] rd);
		logic [23:0] sh;
		sh = {cmd, wd};
		rd = 16'h0000;
		cs_n = 1'b0;
		#20;
		for (int i = 0; i < nbits; i++) begin
			if (i == CMD_BITS && !cmd[CMD_WRITE_BIT]) begin
				#((cmd[5:0] == ADDR_WAVE) ? WAVE_WAIT_NS : READ_WAIT_NS);
			end
			din = sh[23 - i];
			#8;
			sclk = 1'b1;
			#16;
			// a released line reads as the inverse, so a missing drive shows
			if (i >= CMD_BITS) rd[23 - i] = dout_oe ? dout : ~dout;
			if (i < CMD_BITS && dout_oe) oe_early = 1'b1;
			sclk = 1'b0;
			#8;
		end
		#100;
		cs_n = 1'b1;
		// released line shows the inverse of its last level
		din = ~din;
		#250;
	endtask
endmodule // mtr_host_model

// [mtr_pins_tb.sv]
// self-checking bench for the metering pin core
`timescale 1ns/1ns
module mtr_pins_tb;
	import mtr_pkg::*;
	localparam int NOZX = 200;
	logic        clock;
	logic        rst;
	logic        sample_valid;
	logic [15:0] volt_sample;
	logic [15:0] power_sample;
	logic        sclk, cs_n, din, dout, dout_oe;
	logic        pulse, zx, sag_out, sag_oe, irq_out, irq_oe;
	int          failures, compares, pulses, hi_len, last_len, base;
	integer      seed = 32'hB65A;
	logic [15:0] rd, v, prev;
	logic        zx_exp;
	logic [5:0]  ra [5];
	logic [15:0] rv [5];

	mtr_pins #(.NOZX_CYCLES(NOZX)) mtr_pins_inst (.clock(clock), .rst(rst),
		.sample_valid(sample_valid), .volt_sample(volt_sample), .power_sample(power_sample),
		.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.power_pulse_out(pulse), .zero_cross_out(zx), .sag_out(sag_out), .sag_oe(sag_oe),
		.irq_out(irq_out), .irq_oe(irq_oe));
	mtr_host_model mtr_host_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// pulse monitor sees pre-edge levels, so counts stay race free
	always @(posedge clock) begin
		if (pulse) begin
			hi_len <= hi_len + 1;
		end else if (hi_len != 0) begin
			last_len <= hi_len;
			hi_len   <= 0;
		end
		if (pulse && hi_len == 0) pulses <= pulses + 1;
	end

	function automatic logic zx_next(input logic z, input logic [15:0] a, input logic [15:0] b);
		return z ^ (a[15] ^ b[15]);
	endfunction
	task automatic final_report();
		if (failures == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string s);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string s);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %b exp %b", $time, s, got, exp);
		end
	endtask
	task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
		mtr_host_model_inst.xfer({2'b00, a}, 16'h0000, 24, d);
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [15:0] d, input int n);
		logic [15:0] dummy;
		mtr_host_model_inst.xfer({2'b10, a}, d, n, dummy);
	endtask
	task automatic smp(input logic [15:0] vs, input logic [15:0] ps);
		@(posedge clock);
		sample_valid <= 1'b1;
		volt_sample  <= vs;
		power_sample <= ps;
		@(posedge clock);
		sample_valid <= 1'b0;
		@(posedge clock);
		@(negedge clock);
	endtask
	task automatic do_reset();
		@(posedge clock);
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk1(dout_oe | pulse | zx | sag_oe | irq_oe, 1'b0, "reset outputs");
		@(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	initial begin
		rst = 1'b1;
		sample_valid = 1'b0;
		volt_sample = 16'h0000;
		power_sample = 16'h0000;
		pulses = 0;
		hi_len = 0;
		last_len = 0;
		ra = '{ADDR_PULSE_RATE_NUMERATOR, ADDR_PULSE_RATE_DENOMINATOR, ADDR_IRQEN, ADDR_SAGLVL, ADDR_SAGCYC};
		rv = '{PULSE_RATE_NUMERATOR_RST, PULSE_RATE_DENOMINATOR_RST, {13'h0000, IRQEN_RST}, SAGLVL_RST, SAGCYC_RST};
		do_reset();
		for (int i = 0; i < 5; i++) begin
			rd_reg(ra[i], rd);
			chk16(rd, rv[i], "reset value");
		end
		chk1(dout_oe, 1'b0, "dout released");
		chk1(mtr_host_model_inst.oe_early, 1'b0, "early drive");
		for (int k = 0; k < 6; k++) begin
			v = $random(seed);
			wr_reg(ra[k % 5], v, 24);
			rd_reg(ra[k % 5], rd);
			chk16(rd, (ra[k % 5] == ADDR_IRQEN) ? (v & 16'h0007) : v, "write back");
		end
		wr_reg(ADDR_SAGLVL, 16'h1234, 24);
		wr_reg(ADDR_SAGLVL, 16'hEDCB, 20);
		rd_reg(ADDR_SAGLVL, rd);
		chk16(rd, 16'h1234, "aborted write");
		wr_reg(6'h3F, 16'hFFFF, 24);
		rd_reg(6'h3F, rd);
		chk16(rd, 16'h0000, "unmapped");
		do_reset();
		prev = 16'h0001;
		smp(prev, 16'h0000);
		zx_exp = zx;
		for (int k = 0; k < 24; k++) begin
			// forced sign flips on every fifth sample guarantee crossings
			v = (k % 5 == 0) ? ~prev : $random(seed);
			if (v == 16'h0000) v = 16'h0001;
			smp(v, 16'h0000);
			zx_exp = zx_next(zx_exp, prev, v);
			chk1(zx, zx_exp, "zero cross");
			prev = v;
		end
		wr_reg(ADDR_IRQEN, 16'h0004, 24);
		smp(16'h0100, 16'h0000);
		chk1(irq_oe, 1'b1, "irq set");
		chk1(irq_out, 1'b0, "irq level");
		rd_reg(ADDR_RSTSTAT, rd);
		chk16(rd & 16'h0004, 16'h0004, "wave status");
		repeat (2) @(negedge clock);
		chk1(irq_oe, 1'b0, "irq cleared");
		wr_reg(ADDR_IRQEN, 16'h0000, 24);
		smp(16'hFF00, 16'h0000);
		chk1(irq_oe, 1'b0, "irq masked");
		do_reset();
		for (int k = 1; k <= 17; k++) begin
			smp(k[0] ? 16'h0100 : 16'hFF00, 16'h0000);
			if (k == 15 || k == 17) chk1(sag_oe, k == 17, "sag low");
		end
		chk1(sag_out, 1'b0, "sag level");
		do_reset();
		repeat (NOZX - 20) @(negedge clock);
		chk1(sag_oe, 1'b0, "sag early");
		repeat (40) @(negedge clock);
		chk1(sag_oe, 1'b1, "no crossing");
		do_reset();
		wr_reg(ADDR_PULSE_RATE_DENOMINATOR, 16'h0003, 24);
		base = pulses;
		for (int k = 0; k < 8; k++) smp(16'h0100, 16'hFF00);
		for (int k = 0; k < 3; k++) smp(16'h0100, 16'h0100);
		chk16(16'(pulses - base), 16'h0000, "no pulse");
		smp(16'h0100, 16'h0100);
		repeat (CF_PULSE_CYC + 10) @(negedge clock);
		chk16(16'(pulses - base), 16'h0001, "one pulse");
		chk16(16'(last_len), 16'(CF_PULSE_CYC), "pulse width");
		final_report();
	end
endmodule // mtr_pins_tb
